/* hw/cfg_cmd_pkg.sv */
package cfg_cmd_pkg;
	// register byte offsets
	localparam logic [3:0] OFS_CMD    = 4'h0;
	localparam logic [3:0] OFS_RESP   = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_CLIENT = 4'hc;
	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	localparam logic [1:0] AXI_DECERR = 2'h3;
	// header fields
	localparam int HDR_ID_LO  = 24;
	localparam int HDR_LEN_LO = 12;
	localparam int HDR_CODE_W = 11;
	localparam int HDR_LEN_W  = 11;
	localparam int HDR_ID_W   = 4;
	// command codes
	localparam logic [10:0] CMD_CFG_STATUS = 11'h004;
	localparam logic [10:0] CMD_UPD_STATUS = 11'h05b;
	localparam logic [10:0] CMD_UPD_NOTIFY = 11'h05d;
	localparam logic [10:0] CMD_IMG_UPDATE = 11'h05c;
	localparam logic [10:0] CMD_PART_TABLE = 11'h05a;
	localparam logic [10:0] CMD_FL_OPEN    = 11'h032;
	localparam logic [10:0] CMD_FL_CLOSE   = 11'h033;
	localparam logic [10:0] CMD_FL_SELECT  = 11'h034;
	// argument and response word counts
	localparam logic [10:0] ARGS_ZERO = 11'h000;
	localparam logic [10:0] ARGS_ONE  = 11'h001;
	localparam logic [10:0] ARGS_TWO  = 11'h002;
	localparam logic [3:0]  RLEN_NONE = 4'h0;
	localparam logic [3:0]  RLEN_CFG  = 4'h6;
	localparam logic [3:0]  RLEN_UPD  = 4'h9;
	localparam logic [3:0]  RLEN_PART = 4'h4;
	// notify arguments
	localparam logic [31:0] NOTIFY_RETRY_CLR = 32'h0005_0000;
	localparam logic [31:0] NOTIFY_ERROR_CLR = 32'h0006_0000;
	// response error codes
	localparam logic [10:0] ERR_OK        = 11'h000;
	localparam logic [10:0] ERR_BAD_LEN   = 11'h002;
	localparam logic [10:0] ERR_BAD_ARG   = 11'h004;
	localparam logic [10:0] ERR_NOT_OWNER = 11'h008;
	localparam logic [10:0] ERR_BUSY      = 11'h0ff;
	localparam logic [10:0] ERR_UNKNOWN   = 11'h3ff;
	// chip-select field of the select argument
	localparam int CS_ARG_LO = 28;
	localparam int CS_ARG_W  = 4;
	// pin synchroniser settle cycles before strap capture
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARGS = 2'b01,
		ST_EXEC = 2'b10,
		ST_RESP = 2'b11
	} cmd_state_t;
endpackage

/* hw/cfg_cmd_core.sv */
// How it works
// - configuration status, code 4, no args, six words; word 0 zero without error.
// - error word holds major code high sixteen bits, minor code low sixteen.
// - word 1 holds firmware index 31:28, zero 27:24, tool version below.
// - word 2 bit 31 status-out level, bit 30 sampled request-in, 29:8 zero.
// - word 2 bits 7:6 give clock source, 01 internal, 10 external.
// - word 2 bits 2:0 return mode pins caught at power up, 5:3 zero.
// - word 3 reports six soft function values in bits 5 down to 0.
// - words 4 and 5 return error location and details, zero without error.
// - update status, code 5B, no args, nine words; words 0-1 current image.
// - words 2-3 give failing image offset; other words invalid when zero.
// - a request-in rising edge never alters stored failing image data.
// - failing data changes only after image update then successful configuration, or on an error-clear notify.
// - word 8 is the retry counter, counting retries of the current image.
// - notify, code 5D, argument 0x00050000 resets the retry counter.
// - notify argument 0x00060000 clears error info; other values are reserved.
// - open granted only when flash is free and configuration is idle.
// - granted client owns flash exclusively until it closes.
// - close, code 33, no args or response words, releases ownership.
// - select, code 34, one argument chooses the chip-select line.
// - partition table words 2 and 3 carry second table address halves.
// - header bits 27:24 id echoed, bits 22:12 argument count, or response word count in a reply.
// - header bits 10:0 command code or response error, zero is success.
`timescale 1ns/1ps
`default_nettype none
module cfg_cmd_core
	import cfg_cmd_pkg::*;
#(
	parameter int CS_LINES = 4,
	parameter int CLIENT_W = 2
) (
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire logic [3:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [3:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                config_request_in_n,
	input  wire logic [2:0]          mode_select_pins,
	input  wire logic                config_status_out_n,
	input  wire logic [1:0]          clock_source,
	input  wire logic [5:0]          soft_functions,
	input  wire logic [31:0]         config_error,
	input  wire logic [31:0]         config_error_loc,
	input  wire logic [31:0]         config_error_detail,
	input  wire logic [3:0]          firmware_index,
	input  wire logic [23:0]         tool_version,
	input  wire logic [63:0]         current_image,
	input  wire logic [31:0]         update_version,
	input  wire logic [63:0]         first_partition_table,
	input  wire logic [63:0]         second_partition_table,
	input  wire logic                config_in_progress,
	input  wire logic                flash_busy_ext,
	input  wire logic                retry_event,
	input  wire logic                update_config_ok,
	input  wire logic [63:0]         fail_offset_in,
	input  wire logic [31:0]         fail_code_in,
	input  wire logic [31:0]         fail_loc_in,
	input  wire logic [31:0]         fail_detail_in,
	output logic                     image_update_req,
	output logic [31:0]              image_update_addr,
	output logic                     flash_granted,
	output logic [$clog2(CS_LINES)-1:0] flash_cs_sel
);
	localparam int CS_W = $clog2(CS_LINES);

	if (CS_LINES < 2 || CS_LINES > 16 || CLIENT_W < 1 || CLIENT_W > 8) begin : g_chk
		$error("cfg_cmd_core: CS_LINES must be 2..16 and CLIENT_W 1..8");
	end

	cmd_state_t state_reg, state_next;
	logic [HDR_ID_W-1:0]   id_reg;
	logic [HDR_CODE_W-1:0] code_reg;
	logic [HDR_LEN_W-1:0]  len_reg, arg_cnt_reg;
	logic [31:0]           arg0_reg;
	logic [10:0]           err_reg;
	logic [3:0]            resp_len_reg, resp_idx_reg;
	logic [HDR_CODE_W-1:0] resp_code_reg;
	logic [CLIENT_W-1:0]   client_reg, owner_reg;
	logic                  fl_open_reg, armed_reg;
	logic [CS_W-1:0]       cs_reg;
	logic [31:0]           retry_cnt_reg;
	logic [63:0]           fail_off_reg;
	logic [31:0]           fail_code_reg, fail_loc_reg, fail_det_reg;
	logic                  req_s1_reg, req_s2_reg;
	logic [2:0]            mode_select_pins_s1_reg, mode_select_pins_s2_reg, mode_select_pins_cap_reg;
	logic [1:0]            settle_reg;
	logic                  aw_got_reg, w_got_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [3:0]            awaddr_reg;
	logic                  wstrb0_reg, resp_pop;
	logic [31:0]           wdata_reg, rdata_reg;
	logic [1:0]            bresp_reg, rresp_reg;
	logic                  upd_req_reg;
	logic [31:0]           upd_addr_reg;

	// pins cross in through two flops; only the second is read
	always_ff @(posedge clk_sys) begin
		req_s1_reg  <= config_request_in_n;
		req_s2_reg  <= req_s1_reg;
		mode_select_pins_s1_reg <= mode_select_pins;
		mode_select_pins_s2_reg <= mode_select_pins_s1_reg;
	end

	// mode pins caught once after reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			settle_reg   <= 2'h0;
			mode_select_pins_cap_reg <= 3'h0;
		end else if (settle_reg != STRAP_SETTLE + 2'h1) begin
			settle_reg <= settle_reg + 2'h1;
			if (settle_reg == STRAP_SETTLE)
				mode_select_pins_cap_reg <= mode_select_pins_s2_reg;
		end
	end

	// axi write side
	wire aw_hs     = s_axi_awvalid && !aw_got_reg;
	wire w_hs      = s_axi_wvalid && !w_got_reg;
	wire wr_go     = aw_got_reg && w_got_reg && !bvalid_reg;
	wire wr_cmd    = wr_go && awaddr_reg == OFS_CMD;
	wire wr_client = wr_go && awaddr_reg == OFS_CLIENT;
	wire cmd_open  = state_reg == ST_IDLE || state_reg == ST_ARGS;
	wire wr_mapped = awaddr_reg == OFS_CMD || awaddr_reg == OFS_CLIENT;
	wire cmd_take  = wr_cmd && cmd_open;
	wire [1:0] bresp_next = !wr_mapped ? AXI_DECERR :
		(awaddr_reg == OFS_CMD && !cmd_open) ? AXI_SLVERR : AXI_OKAY;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= AXI_OKAY;
			awaddr_reg <= 4'h0;
			wdata_reg  <= 32'h0;
			wstrb0_reg <= 1'b0;
		end else begin
			if (aw_hs) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= {s_axi_awaddr[3:2], 2'h0};
			end
			if (w_hs) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				// strobe kept with the data; the master may drop it once taken
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= bresp_next;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
			end
		end
	end

	// client id register; wstrb lane 0 carries it
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			client_reg <= '0;
		else if (wr_client && wstrb0_reg)
			client_reg <= wdata_reg[CLIENT_W-1:0];
	end

	// command parser
	wire [HDR_LEN_W-1:0] hdr_len = wdata_reg[HDR_LEN_LO+HDR_LEN_W-1:HDR_LEN_LO];
	wire last_arg = arg_cnt_reg + 11'h1 == len_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (cmd_take) state_next = (hdr_len == ARGS_ZERO) ? ST_EXEC : ST_ARGS;
			ST_ARGS: if (cmd_take && last_arg) state_next = ST_EXEC;
			ST_EXEC: state_next = ST_RESP;
			ST_RESP: if (resp_pop && resp_idx_reg == resp_len_reg) state_next = ST_IDLE;
		endcase
	end

	// expected argument count per command
	logic [HDR_LEN_W-1:0] exp_len;
	logic                 known;
	always_comb begin
		known   = 1'b1;
		exp_len = ARGS_ZERO;
		case (code_reg)
			CMD_CFG_STATUS, CMD_UPD_STATUS, CMD_PART_TABLE,
			CMD_FL_OPEN, CMD_FL_CLOSE: exp_len = ARGS_ZERO;
			CMD_UPD_NOTIFY, CMD_FL_SELECT: exp_len = ARGS_ONE;
			CMD_IMG_UPDATE: exp_len = ARGS_TWO;
			default: known = 1'b0;
		endcase
	end

	wire exec      = state_reg == ST_EXEC;
	wire len_ok    = known && len_reg == exp_len;
	// only the owner may close or select
	wire is_owner  = fl_open_reg && owner_reg == client_reg;
	wire fl_busy   = fl_open_reg || flash_busy_ext || config_in_progress;
	wire [CS_ARG_W-1:0] cs_arg = arg0_reg[CS_ARG_LO+CS_ARG_W-1:CS_ARG_LO];
	wire cs_arg_ok = {1'b0, cs_arg} < (CS_ARG_W+1)'(CS_LINES);
	wire notify_ok = arg0_reg == NOTIFY_RETRY_CLR || arg0_reg == NOTIFY_ERROR_CLR;

	// error code chosen, zero means success
	wire [10:0] err_next =
		!known ? ERR_UNKNOWN :
		!len_ok ? ERR_BAD_LEN :
		(code_reg == CMD_FL_OPEN && fl_busy) ? ERR_BUSY :
		((code_reg == CMD_FL_CLOSE || code_reg == CMD_FL_SELECT) && !is_owner) ? ERR_NOT_OWNER :
		(code_reg == CMD_FL_SELECT && !cs_arg_ok) ? ERR_BAD_ARG :
		(code_reg == CMD_UPD_NOTIFY && !notify_ok) ? ERR_BAD_ARG : ERR_OK;
	wire ok = err_next == ERR_OK;
	wire [3:0] rlen_ok = code_reg == CMD_CFG_STATUS ? RLEN_CFG :
		code_reg == CMD_UPD_STATUS ? RLEN_UPD :
		code_reg == CMD_PART_TABLE ? RLEN_PART : RLEN_NONE;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_reg     <= ST_IDLE;
			id_reg        <= '0;
			code_reg      <= '0;
			len_reg       <= '0;
			arg_cnt_reg   <= '0;
			arg0_reg      <= 32'h0;
			upd_addr_reg  <= 32'h0;
			err_reg       <= ERR_OK;
			resp_len_reg  <= RLEN_NONE;
			resp_code_reg <= '0;
		end else begin
			state_reg <= state_next;
			// id and argument count taken from the header
			if (state_reg == ST_IDLE && cmd_take) begin
				id_reg      <= wdata_reg[HDR_ID_LO+HDR_ID_W-1:HDR_ID_LO];
				len_reg     <= hdr_len;
				code_reg    <= wdata_reg[HDR_CODE_W-1:0];
				arg_cnt_reg <= '0;
			end
			if (state_reg == ST_ARGS && cmd_take) begin
				arg_cnt_reg <= arg_cnt_reg + 11'h1;
				if (arg_cnt_reg == ARGS_ZERO)
					arg0_reg <= wdata_reg;
			end
			if (exec) begin
				err_reg       <= err_next;
				resp_code_reg <= code_reg;
				// refused commands carry no response words
				resp_len_reg  <= ok ? rlen_ok : RLEN_NONE;
				if (ok && code_reg == CMD_IMG_UPDATE)
					upd_addr_reg <= arg0_reg;
			end
		end
	end

	// flash ownership and chip select
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fl_open_reg <= 1'b0;
			owner_reg   <= '0;
			cs_reg      <= '0;
			upd_req_reg <= 1'b0;
			armed_reg   <= 1'b0;
		end else begin
			upd_req_reg <= exec && ok && code_reg == CMD_IMG_UPDATE;
			// grant only when free and not configuring
			if (exec && ok && code_reg == CMD_FL_OPEN) begin
				fl_open_reg <= 1'b1;
				owner_reg   <= client_reg;
			end
			if (exec && ok && code_reg == CMD_FL_CLOSE)
				fl_open_reg <= 1'b0;
			if (exec && ok && code_reg == CMD_FL_SELECT)
				cs_reg <= cs_arg[CS_W-1:0];
			// arm on image update, disarm on its successful configuration
			if (exec && ok && code_reg == CMD_IMG_UPDATE)
				armed_reg <= 1'b1;
			else if (update_config_ok)
				armed_reg <= 1'b0;
		end
	end

	wire notify_exec = exec && ok && code_reg == CMD_UPD_NOTIFY;
	wire retry_clr   = notify_exec && arg0_reg == NOTIFY_RETRY_CLR;
	wire err_clr     = notify_exec && arg0_reg == NOTIFY_ERROR_CLR;
	wire fail_latch  = update_config_ok && armed_reg;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			retry_cnt_reg <= 32'h0;
			fail_off_reg  <= 64'h0;
			fail_code_reg <= 32'h0;
			fail_loc_reg  <= 32'h0;
			fail_det_reg  <= 32'h0;
		end else begin
			// retry counter; a retry in the clearing cycle still counts
			if (retry_event)
				retry_cnt_reg <= (retry_clr ? 32'h0 : retry_cnt_reg) + 32'h1;
			else if (retry_clr)
				retry_cnt_reg <= 32'h0;
			// only the armed latch or a clear touch failing data
			if (fail_latch) begin
				fail_off_reg  <= fail_offset_in;
				fail_code_reg <= fail_code_in;
				fail_loc_reg  <= fail_loc_in;
				fail_det_reg  <= fail_detail_in;
			end else if (err_clr) begin
				fail_off_reg  <= 64'h0;
				fail_code_reg <= 32'h0;
				fail_loc_reg  <= 32'h0;
				fail_det_reg  <= 32'h0;
			end
		end
	end

	// response words, built live from state so a read sees current values
	wire fail_valid = fail_off_reg != 64'h0;
	wire [31:0] resp_hdr = {4'h0, id_reg, 1'b0, 7'h0, resp_len_reg, 1'b0, err_reg};
	logic [31:0] data_word;
	always_comb begin
		data_word = 32'h0;
		if (resp_code_reg == CMD_CFG_STATUS) begin
			case (resp_idx_reg)
				// error word passed as major/minor halves
				4'h1: data_word = config_error;
				4'h2: data_word = {firmware_index, 4'h0, tool_version};
				4'h3: data_word = {config_status_out_n, req_s2_reg, 22'h0,
					clock_source, 3'h0, mode_select_pins_cap_reg};
				4'h4: data_word = {26'h0, soft_functions};
				4'h5: data_word = config_error_loc;
				4'h6: data_word = config_error_detail;
				default: data_word = 32'h0;
			endcase
		end else if (resp_code_reg == CMD_UPD_STATUS) begin
			case (resp_idx_reg)
				4'h1: data_word = current_image[63:32];
				4'h2: data_word = current_image[31:0];
				// failing image offset; dependent words zero when none
				4'h3: data_word = fail_off_reg[63:32];
				4'h4: data_word = fail_off_reg[31:0];
				4'h5: data_word = fail_valid ? fail_code_reg : 32'h0;
				4'h6: data_word = fail_valid ? update_version : 32'h0;
				4'h7: data_word = fail_valid ? fail_loc_reg : 32'h0;
				4'h8: data_word = fail_valid ? fail_det_reg : 32'h0;
				4'h9: data_word = retry_cnt_reg;
				default: data_word = 32'h0;
			endcase
		end else if (resp_code_reg == CMD_PART_TABLE) begin
			case (resp_idx_reg)
				4'h1: data_word = first_partition_table[63:32];
				4'h2: data_word = first_partition_table[31:0];
				4'h3: data_word = second_partition_table[63:32];
				4'h4: data_word = second_partition_table[31:0];
				default: data_word = 32'h0;
			endcase
		end
	end

	// axi read side; reading the response register pops one word
	wire ar_hs      = s_axi_arvalid && arready_reg;
	wire [3:0] ar_a = {s_axi_araddr[3:2], 2'h0};
	assign resp_pop = ar_hs && ar_a == OFS_RESP && state_reg == ST_RESP;
	wire [31:0] resp_word = resp_idx_reg == 4'h0 ? resp_hdr : data_word;
	wire [3:0] remain = state_reg == ST_RESP ? resp_len_reg - resp_idx_reg + 4'h1 : 4'h0;
	wire [31:0] status_word = {4'h0, CS_ARG_W'(cs_reg), 8'(owner_reg), 3'h0,
		fl_open_reg, remain, 6'h0, state_reg == ST_RESP, cmd_open};
	wire rd_mapped = ar_a == OFS_RESP || ar_a == OFS_STATUS || ar_a == OFS_CLIENT;
	wire [31:0] rd_word = ar_a == OFS_RESP ? (resp_pop ? resp_word : 32'h0) :
		ar_a == OFS_STATUS ? status_word :
		ar_a == OFS_CLIENT ? 32'(client_reg) : 32'h0;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			arready_reg  <= 1'b1;
			rvalid_reg   <= 1'b0;
			rdata_reg    <= 32'h0;
			rresp_reg    <= AXI_OKAY;
			resp_idx_reg <= 4'h0;
		end else begin
			if (ar_hs) begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rdata_reg   <= rd_word;
				rresp_reg   <= rd_mapped ? AXI_OKAY : AXI_DECERR;
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
			if (exec)
				resp_idx_reg <= 4'h0;
			else if (resp_pop)
				resp_idx_reg <= resp_idx_reg + 4'h1;
		end
	end

	assign s_axi_awready     = !aw_got_reg;
	assign s_axi_wready      = !w_got_reg;
	assign s_axi_bvalid      = bvalid_reg;
	assign s_axi_bresp       = bresp_reg;
	assign s_axi_arready     = arready_reg;
	assign s_axi_rvalid      = rvalid_reg;
	assign s_axi_rdata       = rdata_reg;
	assign s_axi_rresp       = rresp_reg;
	assign image_update_req  = upd_req_reg;
	assign image_update_addr = upd_addr_reg;
	assign flash_granted     = fl_open_reg;
	assign flash_cs_sel      = cs_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_cfg_len;
		exec && ok && code_reg == CMD_CFG_STATUS |=> resp_len_reg == RLEN_CFG && err_reg == ERR_OK;
	endproperty
	a_cfg_len: assert property (p_cfg_len) else $error("cfg status length wrong");
	property p_fw_word;
		resp_pop && resp_code_reg == CMD_CFG_STATUS && resp_idx_reg == 4'h2
			|=> rdata_reg[31:24] == {$past(firmware_index), 4'h0};
	endproperty
	a_fw_word: assert property (p_fw_word) else $error("firmware word wrong");
	property p_retry_clr;
		retry_clr && !retry_event |=> retry_cnt_reg == 32'h0;
	endproperty
	a_retry_clr: assert property (p_retry_clr) else $error("retry not cleared");
	property p_retry_inc;
		retry_event && !retry_clr |=> retry_cnt_reg == $past(retry_cnt_reg) + 32'h1;
	endproperty
	a_retry_inc: assert property (p_retry_inc) else $error("retry not counted");
	property p_fail_hold;
		!fail_latch && !err_clr |=> $stable(fail_off_reg) && $stable(fail_code_reg);
	endproperty
	a_fail_hold: assert property (p_fail_hold) else $error("failing info changed");
	property p_err_clr;
		err_clr && !fail_latch |=> fail_off_reg == 64'h0;
	endproperty
	a_err_clr: assert property (p_err_clr) else $error("error info kept");
	property p_open_refuse;
		exec && len_ok && code_reg == CMD_FL_OPEN && fl_busy
			|=> err_reg != ERR_OK && resp_len_reg == RLEN_NONE && fl_open_reg == $past(fl_open_reg)
			##1 state_reg == ST_RESP;
	endproperty
	a_open_refuse: assert property (p_open_refuse) else $error("busy open granted");
	property p_exclusive;
		fl_open_reg && exec && owner_reg != client_reg |=> fl_open_reg && $stable(owner_reg);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("non-owner took flash");
	property p_close;
		exec && len_ok && code_reg == CMD_FL_CLOSE && is_owner |=> !fl_open_reg && resp_len_reg == RLEN_NONE;
	endproperty
	a_close: assert property (p_close) else $error("close did not release");
	property p_cs_cause;
		$changed(cs_reg) |-> $past(exec && ok && code_reg == CMD_FL_SELECT);
	endproperty
	a_cs_cause: assert property (p_cs_cause) else $error("chip select moved");
	property p_hdr_id;
		resp_pop && resp_idx_reg == 4'h0 |=> rdata_reg[27:24] == $past(id_reg)
			&& rdata_reg[22:12] == 11'($past(resp_len_reg));
	endproperty
	a_hdr_id: assert property (p_hdr_id) else $error("header id wrong");

	c_cfg:   cover property (exec && ok && code_reg == CMD_CFG_STATUS ##[1:100] state_reg == ST_IDLE);
	c_open:  cover property (exec && ok && code_reg == CMD_FL_OPEN ##[1:400] !fl_open_reg);
	c_latch: cover property (image_update_req ##[1:100] fail_latch);
endmodule
`default_nettype wire

/* verif/cfg_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
// manager-side levels seen by the command block; fixed so replies are predictable
module cfg_side_model (
	output logic        config_status_out_n,
	output logic [2:0]  mode_select_pins,
	output logic [1:0]  clock_source,
	output logic [5:0]  soft_functions,
	output logic [31:0] config_error,
	output logic [31:0] config_error_loc,
	output logic [31:0] config_error_detail,
	output logic [3:0]  firmware_index,
	output logic [23:0] tool_version,
	output logic [63:0] current_image,
	output logic [31:0] update_version,
	output logic [63:0] first_partition_table,
	output logic [63:0] second_partition_table,
	output logic [63:0] fail_offset_in,
	output logic [31:0] fail_code_in,
	output logic [31:0] fail_loc_in,
	output logic [31:0] fail_detail_in
);
	assign config_status_out_n = 1'b1;
	assign mode_select_pins = 3'h5;
	assign clock_source = 2'h2;
	assign soft_functions = 6'h2a;
	assign config_error = 32'h0001_0002;
	assign config_error_loc = 32'h0000_0a0c;
	assign config_error_detail = 32'h0000_00d1;
	assign firmware_index = 4'h3;
	assign tool_version = 24'h15_0301;
	assign current_image = 64'h0000_0001_0020_0000;
	assign update_version = 32'h0000_0107;
	assign first_partition_table = 64'h0000_0000_0010_0000;
	assign second_partition_table = 64'h0000_0002_0018_0000;
	assign fail_offset_in = 64'h0000_0003_0400_0000;
	assign fail_code_in = 32'h0002_0005;
	assign fail_loc_in = 32'h0000_0011;
	assign fail_detail_in = 32'h0000_0022;
endmodule
`default_nettype wire

/* verif/config_update_flash_access_cmds_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module config_update_flash_access_cmds_tb import cfg_cmd_pkg::*;;
	logic clk_sys = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic config_request_in_n = 1'b1, config_in_progress = 1'b0, flash_busy_ext = 1'b0;
	logic retry_event = 1'b0, update_config_ok = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, rh, w [0:15];
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic config_status_out_n, flash_granted, image_update_req;
	wire logic [1:0] s_axi_bresp, s_axi_rresp, clock_source, flash_cs_sel;
	wire logic [2:0] mode_select_pins;
	wire logic [3:0] firmware_index;
	wire logic [5:0] soft_functions;
	wire logic [23:0] tool_version;
	wire logic [31:0] s_axi_rdata, config_error, config_error_loc, config_error_detail;
	wire logic [31:0] update_version, fail_code_in, fail_loc_in, fail_detail_in, image_update_addr;
	wire logic [63:0] current_image, first_partition_table, second_partition_table, fail_offset_in;
	int fail_count = 0, checks = 0, upd_pulses = 0;
	cfg_cmd_core i_dut (.*);
	cfg_side_model i_mdl (.*);
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (image_update_req === 1'b1) upd_pulses++;
	function automatic logic [31:0] h(input logic [3:0] id, input logic [10:0] n, c);
		return {4'h0, id, 1'b0, n, 1'b0, c};
	endfunction
	task automatic chk(input string s, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", s, e, g);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		chk("bresp", AXI_OKAY, s_axi_bresp);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		chk("rresp", AXI_OKAY, s_axi_rresp);
	endtask
	// header, its arguments, then the whole reply
	task automatic cmd(input logic [31:0] hw, a0, a1);
		logic [31:0] s;
		wr(OFS_CMD, hw);
		if (hw[22:12] > 0) wr(OFS_CMD, a0);
		if (hw[22:12] > 1) wr(OFS_CMD, a1);
		s = 32'h0;
		while (s[1] !== 1'b1) rd(OFS_STATUS, s);
		rd(OFS_RESP, rh);
		for (int i = 0; i < rh[22:12] && i < 16; i++) rd(OFS_RESP, w[i]);
	endtask
	task automatic upd;
		cmd(h(4'h2, ARGS_ZERO, CMD_UPD_STATUS), 32'h0, 32'h0);
	endtask
	task automatic test_done;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		cmd(h(4'h1, ARGS_ZERO, CMD_CFG_STATUS), 32'h0, 32'h0);
		chk("cfg hdr", h(4'h1, 11'h006, ERR_OK), rh);
		chk("cfg w0", config_error, w[0]);
		chk("cfg w1", {firmware_index, 4'h0, tool_version}, w[1]);
		chk("cfg w2", {2'h3, 22'h0, clock_source, 3'h0, mode_select_pins}, w[2]);
		chk("cfg w3", {26'h0, soft_functions}, w[3]);
		chk("cfg w4", config_error_loc, w[4]);
		chk("cfg w5", config_error_detail, w[5]);
		repeat (2) begin
			@(posedge clk_sys);
			retry_event <= 1'b1;
			@(posedge clk_sys);
			retry_event <= 1'b0;
		end
		upd;
		chk("upd hdr", h(4'h2, 11'h009, ERR_OK), rh);
		chk("upd w0", current_image[63:32], w[0]);
		chk("upd w1", current_image[31:0], w[1]);
		chk("upd w23", 32'h0, w[2] | w[3]);
		chk("retry", 32'h2, w[8]);
		cmd(h(4'h3, ARGS_ONE, CMD_UPD_NOTIFY), NOTIFY_RETRY_CLR, 32'h0);
		chk("notify", h(4'h3, ARGS_ZERO, ERR_OK), rh);
		upd;
		chk("retry clr", 32'h0, w[8]);
		cmd(h(4'h4, ARGS_ONE, CMD_UPD_NOTIFY), 32'h0007_0000, 32'h0);
		chk("notify rsvd", h(4'h4, ARGS_ZERO, ERR_BAD_ARG), rh);
		@(posedge clk_sys);
		config_request_in_n <= 1'b0;
		update_config_ok <= 1'b1;
		@(posedge clk_sys);
		update_config_ok <= 1'b0;
		cmd(h(4'he, ARGS_ZERO, CMD_CFG_STATUS), 32'h0, 32'h0);
		chk("req pin", 32'h0, w[2] & 32'h4000_0000);
		config_request_in_n <= 1'b1;
		upd;
		chk("no arm", 32'h0, w[2] | w[3]);
		cmd(h(4'h5, ARGS_TWO, CMD_IMG_UPDATE), 32'h0400_0000, 32'h0);
		chk("img hdr", h(4'h5, ARGS_ZERO, ERR_OK), rh);
		chk("img addr", 32'h0400_0000, image_update_addr);
		chk("img req", 32'h1, upd_pulses);
		@(posedge clk_sys);
		update_config_ok <= 1'b1;
		@(posedge clk_sys);
		update_config_ok <= 1'b0;
		upd;
		chk("fail hi", fail_offset_in[63:32], w[2]);
		chk("fail lo", fail_offset_in[31:0], w[3]);
		chk("fail code", fail_code_in, w[4]);
		cmd(h(4'h6, ARGS_ONE, CMD_UPD_NOTIFY), NOTIFY_ERROR_CLR, 32'h0);
		upd;
		chk("err clr", 32'h0, w[2] | w[3] | w[4]);
		config_in_progress <= 1'b1;
		cmd(h(4'h7, ARGS_ZERO, CMD_FL_OPEN), 32'h0, 32'h0);
		chk("open cfg", h(4'h7, ARGS_ZERO, ERR_BUSY), rh);
		config_in_progress <= 1'b0;
		cmd(h(4'h8, ARGS_ZERO, CMD_FL_OPEN), 32'h0, 32'h0);
		chk("open", h(4'h8, ARGS_ZERO, ERR_OK), rh);
		cmd(h(4'h9, ARGS_ZERO, CMD_FL_OPEN), 32'h0, 32'h0);
		chk("open twice", h(4'h9, ARGS_ZERO, ERR_BUSY), rh);
		wr(OFS_CLIENT, 32'h1);
		cmd(h(4'ha, ARGS_ZERO, CMD_FL_CLOSE), 32'h0, 32'h0);
		chk("close other", h(4'ha, ARGS_ZERO, ERR_NOT_OWNER), rh);
		wr(OFS_CLIENT, 32'h0);
		cmd(h(4'hb, ARGS_ONE, CMD_FL_SELECT), 32'h2000_0000, 32'h0);
		chk("select", h(4'hb, ARGS_ZERO, ERR_OK), rh);
		chk("cs", 32'h2, {30'h0, flash_cs_sel});
		cmd(h(4'hc, ARGS_ZERO, CMD_FL_CLOSE), 32'h0, 32'h0);
		chk("close", h(4'hc, ARGS_ZERO, ERR_OK), rh);
		chk("granted", 32'h0, {31'h0, flash_granted});
		cmd(h(4'hd, ARGS_ZERO, CMD_PART_TABLE), 32'h0, 32'h0);
		chk("spt w2", second_partition_table[63:32], w[2]);
		chk("spt w3", second_partition_table[31:0], w[3]);
		test_done;
	end
endmodule
`default_nettype wire
